/* rtl/prot_write_path.sv */
`timescale 1ns/1ps
`default_nettype none
module prot_write_path #(
  parameter int BLK_BYTES = 512
) (
  input wire logic clk_i, // 20 MHz controller clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte enables
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic host_valid_i, // Host data byte valid
  input wire logic [7:0] host_data_i, // Host data byte
  output logic host_ready_o, // Host data byte taken
  input wire logic meta_valid_i, // Separate metadata valid
  input wire logic [7:0] meta_data_i, // Separate metadata byte
  output logic meta_ready_o, // Separate metadata taken
  output logic media_valid_o, // Media byte valid
  output logic [7:0] media_data_o, // Media byte
  output logic media_last_o, // Last byte of a block
  input wire logic media_ready_i // Media accepts byte
);

  // Byte index is 16 bits, metadata adds up to 255 more
  if (BLK_BYTES < 1 || BLK_BYTES > 32768) begin : g_bad_blk
    $error("BLK_BYTES out of range");
  end

  localparam logic [15:0] BLK = 16'(BLK_BYTES);

  typedef enum logic [1:0] {IDLE, XFER, EVAL} state_t;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_t st_ff, nxt_st;
  prot_pkg::format_t fmt_ff, nxt_fmt;
  prot_pkg::command_t cmd_ff, nxt_cmd;
  logic [15:0] app_ff, nxt_app;
  logic [31:0] ref0_ff, nxt_ref0;
  logic [31:0] ref_ff, nxt_ref;
  logic [15:0] idx_ff, nxt_idx;
  logic [15:0] blk_ff, nxt_blk;
  logic [15:0] crc_ff, nxt_crc;
  logic [63:0] tup_ff, nxt_tup;
  logic done_ff, nxt_done;
  logic [1:0] err_ff, nxt_err;
  logic ack_ff, nxt_ack;
  logic [31:0] rd_ff, nxt_rd;
  logic hrdy_ff, nxt_hrdy;
  logic mrdy_ff, nxt_mrdy;
  logic ov_ff, nxt_ov;
  logic [7:0] od_ff, nxt_od;
  logic ol_ff, nxt_ol;

  // ----------------------------------------------------------------
  // Byte position decode
  // ----------------------------------------------------------------
  logic [15:0] md16, last_idx, moff, pi_base;
  logic in_meta, in_pi, covered, prot, gen_mode, need_host;
  logic from_meta, slot_free, take, gen_fire, move, last;
  logic [2:0] pi_k;
  logic [7:0] src_byte, gen_byte, out_byte;
  logic [15:0] crc_next;
  logic [63:0] gen_tuple;

  always_comb begin
    md16 = {8'h00, fmt_ff.metadata_size};
    last_idx = BLK + md16 - 16'h0001;
    in_meta = idx_ff >= BLK;
    moff = idx_ff - BLK;
    pi_base = fmt_ff.tuple_first ? 16'h0000
            : md16 - {8'h00, prot_pkg::TUPLE_BYTES};
    prot = fmt_ff.prot_en && md16 >= {8'h00, prot_pkg::TUPLE_BYTES};
    in_pi = prot && in_meta && moff >= pi_base
         && moff < pi_base + {8'h00, prot_pkg::TUPLE_BYTES};
    pi_k = 3'(moff - pi_base);
    covered = !in_meta || (!fmt_ff.tuple_first && !in_pi);
    gen_mode = prot && cmd_ff.protection_action_bit;
    // no host metadata for eight-byte format when generating
    need_host = !(gen_mode && in_meta
               && md16 == {8'h00, prot_pkg::TUPLE_BYTES});
    from_meta = in_meta && fmt_ff.separate_buffer;
    slot_free = !ov_ff || media_ready_i;
    take = (hrdy_ff && host_valid_i) || (mrdy_ff && meta_valid_i);
    gen_fire = st_ff == XFER && !need_host && slot_free;
    move = take || gen_fire;
    last = idx_ff == last_idx;
    src_byte = mrdy_ff ? meta_data_i : host_data_i;
    gen_tuple = {crc_ff, app_ff, ref_ff};
    gen_byte = gen_tuple[8'(63 - 8 * int'(pi_k)) -: 8];
    // replace only tuple bytes when generating
    out_byte = (gen_mode && in_pi) ? gen_byte : src_byte;
  end

  crc16_byte u_crc (
    .crc_i(crc_ff),
    .data_i(src_byte),
    .crc_o(crc_next)
  );

  // ----------------------------------------------------------------
  // Tuple check
  // ----------------------------------------------------------------
  logic [15:0] t_guard, t_app;
  logic [31:0] t_ref;
  logic escape;
  logic [1:0] chk_err;

  always_comb begin
    t_guard = tup_ff[63:48];
    t_app = tup_ff[47:32];
    t_ref = tup_ff[31:0];
    if (fmt_ff.prot_type == prot_pkg::TYPE_THREE) begin
      escape = t_app == prot_pkg::APP_ESCAPE
            && t_ref == prot_pkg::REF_ESCAPE;
    end else begin
      escape = t_app == prot_pkg::APP_ESCAPE;
    end
    chk_err = prot_pkg::ERR_NONE;
    if (!escape) begin
      if (cmd_ff.chk_guard && t_guard != crc_ff) begin
        chk_err = prot_pkg::ERR_GUARD;
      end else if (cmd_ff.chk_app && t_app != app_ff) begin
        chk_err = prot_pkg::ERR_APP;
      end else if (cmd_ff.chk_ref && t_ref != ref_ff) begin
        chk_err = prot_pkg::ERR_REF;
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic wr, rd;
  logic [31:0] wmask;

  always_comb begin
    nxt_st = st_ff;
    nxt_fmt = fmt_ff;
    nxt_cmd = cmd_ff;
    nxt_app = app_ff;
    nxt_ref0 = ref0_ff;
    nxt_ref = ref_ff;
    nxt_idx = idx_ff;
    nxt_blk = blk_ff;
    nxt_crc = crc_ff;
    nxt_tup = tup_ff;
    nxt_done = done_ff;
    nxt_err = err_ff;
    nxt_rd = rd_ff;
    nxt_ov = ov_ff;
    nxt_od = od_ff;
    nxt_ol = ol_ff;
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
             {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wr = wb_cyc_i && wb_stb_i && !ack_ff && wb_we_i;
    rd = wb_cyc_i && wb_stb_i && !ack_ff && !wb_we_i;
    nxt_ack = wb_cyc_i && wb_stb_i && !ack_ff;
    nxt_cmd.start = 1'b0;

    // Register writes
    if (wr) begin
      case (wb_adr_i)
        prot_pkg::OFS_FORMAT: begin
          // format frozen while a command runs
          if (st_ff == IDLE) begin
            nxt_fmt = (fmt_ff & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
          end
        end
        prot_pkg::OFS_COMMAND: begin
          if (st_ff == IDLE) begin
            nxt_cmd = (cmd_ff & ~wmask) | (wb_dat_i & wmask);
          end
        end
        prot_pkg::OFS_APP_TAG: begin
          if (st_ff == IDLE) begin
            nxt_app = (app_ff & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
          end
        end
        prot_pkg::OFS_REF_TAG: begin
          if (st_ff == IDLE) begin
            nxt_ref0 = (ref0_ff & ~wmask) | (wb_dat_i & wmask);
          end
        end
        prot_pkg::OFS_STATUS: begin
          if (wb_sel_i[0] && wb_dat_i[1]) begin
            nxt_done = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    if (rd) begin
      case (wb_adr_i)
        prot_pkg::OFS_FORMAT: nxt_rd = {16'h0000, fmt_ff};
        prot_pkg::OFS_COMMAND: nxt_rd = cmd_ff;
        prot_pkg::OFS_APP_TAG: nxt_rd = {16'h0000, app_ff};
        prot_pkg::OFS_REF_TAG: nxt_rd = ref0_ff;
        prot_pkg::OFS_STATUS: nxt_rd = {blk_ff, 12'h000, err_ff,
                                        done_ff, st_ff != IDLE};
        prot_pkg::OFS_CUR_REF: nxt_rd = ref_ff;
        default: nxt_rd = 32'h00000000;
      endcase
    end

    // Media output slot
    if (ov_ff && media_ready_i) begin
      nxt_ov = 1'b0;
    end
    if (move) begin
      nxt_ov = 1'b1;
      nxt_od = out_byte;
      nxt_ol = last;
    end

    case (st_ff)
      IDLE: begin
        if (wr && wb_adr_i == prot_pkg::OFS_COMMAND && wb_sel_i[0]
            && wb_dat_i[0] && wb_dat_i[31:16] != 16'h0000) begin
          nxt_st = XFER;
          nxt_idx = 16'h0000;
          nxt_blk = 16'h0000;
          nxt_crc = prot_pkg::CRC_SEED;
          nxt_err = prot_pkg::ERR_NONE;
          nxt_ref = ref0_ff;
        end
      end
      XFER: begin
        if (move) begin
          if (covered) begin
            nxt_crc = crc_next;
          end
          if (in_pi) begin
            nxt_tup = {tup_ff[55:0], src_byte};
          end
          nxt_idx = idx_ff + 16'h0001;
          if (last) begin
            nxt_st = EVAL;
          end
        end
      end
      EVAL: begin
        if (prot && !gen_mode && err_ff == prot_pkg::ERR_NONE) begin
          nxt_err = chk_err;
        end
        if (fmt_ff.prot_type != prot_pkg::TYPE_THREE) begin
          nxt_ref = ref_ff + 32'h00000001;
        end
        nxt_crc = prot_pkg::CRC_SEED;
        nxt_idx = 16'h0000;
        nxt_blk = blk_ff + 16'h0001;
        if (blk_ff + 16'h0001 == cmd_ff.block_count) begin
          nxt_st = IDLE;
          nxt_done = 1'b1;
        end else begin
          nxt_st = XFER;
        end
      end
      default: nxt_st = IDLE;
    endcase

    // Ready asserted only into an empty slot, dropped after a take
    nxt_hrdy = nxt_st == XFER && st_ff == XFER && need_host && !from_meta
            && slot_free && !move;
    nxt_mrdy = nxt_st == XFER && st_ff == XFER && need_host && from_meta
            && slot_free && !move;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= IDLE;
      fmt_ff <= prot_pkg::FORMAT_RST;
      cmd_ff <= prot_pkg::COMMAND_RST;
      app_ff <= 16'h0000;
      ref0_ff <= 32'h00000000;
      ref_ff <= 32'h00000000;
      idx_ff <= 16'h0000;
      blk_ff <= 16'h0000;
      crc_ff <= prot_pkg::CRC_SEED;
      tup_ff <= 64'h0000000000000000;
      done_ff <= 1'b0;
      err_ff <= prot_pkg::ERR_NONE;
      ack_ff <= 1'b0;
      rd_ff <= 32'h00000000;
      hrdy_ff <= 1'b0;
      mrdy_ff <= 1'b0;
      ov_ff <= 1'b0;
      od_ff <= 8'h00;
      ol_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      fmt_ff <= nxt_fmt;
      cmd_ff <= nxt_cmd;
      app_ff <= nxt_app;
      ref0_ff <= nxt_ref0;
      ref_ff <= nxt_ref;
      idx_ff <= nxt_idx;
      blk_ff <= nxt_blk;
      crc_ff <= nxt_crc;
      tup_ff <= nxt_tup;
      done_ff <= nxt_done;
      err_ff <= nxt_err;
      ack_ff <= nxt_ack;
      rd_ff <= nxt_rd;
      hrdy_ff <= nxt_hrdy;
      mrdy_ff <= nxt_mrdy;
      ov_ff <= nxt_ov;
      od_ff <= nxt_od;
      ol_ff <= nxt_ol;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rd_ff;
  assign host_ready_o = hrdy_ff;
  assign meta_ready_o = mrdy_ff;
  assign media_valid_o = ov_ff;
  assign media_data_o = od_ff;
  assign media_last_o = ol_ff;

endmodule : prot_write_path
`default_nettype wire

/* rtl/prot_pkg.sv */
// Functional notes
// - Inline mode: metadata follows block data.
// - One metadata mechanism per format, fixed.
// - Tuple sits at first or last eight.
// - Tuple first: guard covers data only.
// - Tuple last: guard covers preceding metadata.
// - Guard is a CRC-16 over data.
// - No alternative checksum for the guard.
// - Application tag opaque except escape value.
// - Reference tag ties block to address.
// - Protection types one, two, three.
// - Action bit picks check or generate.
// - Unprotected format passes bytes untouched.
// - Action clear: pass unchanged, check tuple.
// - Failed check reports guard, app, ref.
// - Eight-byte metadata: generate and append tuple.
// - Larger metadata: overwrite tuple region.
// - Tuple: CRC, command tag, computed reference.
// - Types one, two: reference increments per block.
// - All-ones app tag skips checks; type three also needs all-ones ref tag.
package prot_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FORMAT = 8'h00;
  localparam logic [7:0] OFS_COMMAND = 8'h04;
  localparam logic [7:0] OFS_APP_TAG = 8'h08;
  localparam logic [7:0] OFS_REF_TAG = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_CUR_REF = 8'h14;

  // ----------------------------------------------------------------
  // Guard and tuple constants
  // ----------------------------------------------------------------
  localparam logic [15:0] CRC_POLY = 16'h8BB7;
  localparam logic [15:0] CRC_SEED = 16'h0000;
  localparam logic [7:0] TUPLE_BYTES = 8'h08;
  localparam logic [15:0] APP_ESCAPE = 16'hFFFF;
  localparam logic [31:0] REF_ESCAPE = 32'hFFFFFFFF;

  localparam logic [1:0] TYPE_ONE = 2'h1;
  localparam logic [1:0] TYPE_TWO = 2'h2;
  localparam logic [1:0] TYPE_THREE = 2'h3;

  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_GUARD = 2'h1;
  localparam logic [1:0] ERR_APP = 2'h2;
  localparam logic [1:0] ERR_REF = 2'h3;

  // Namespace format word, FORMAT register low half
  typedef struct packed {
    logic [7:0] metadata_size;
    logic [2:0] unused;
    logic separate_buffer;
    logic tuple_first;
    logic [1:0] prot_type;
    logic prot_en;
  } format_t;

  localparam format_t FORMAT_RST = '0;

  // Per-command controls, COMMAND register
  typedef struct packed {
    logic [15:0] block_count;
    logic [10:0] unused;
    logic chk_ref;
    logic chk_app;
    logic chk_guard;
    logic protection_action_bit;
    logic start;
  } command_t;

  localparam command_t COMMAND_RST = '0;

endpackage : prot_pkg

/* rtl/crc16_byte.sv */
`timescale 1ns/1ps
`default_nettype none
module crc16_byte (
  input wire logic [15:0] crc_i, // Running guard value
  input wire logic [7:0] data_i, // Byte in transfer order
  output logic [15:0] crc_o // Guard after this byte
);

  always_comb begin
    logic [15:0] c;
    logic fb;
    c = crc_i;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ data_i[i];
      c = {c[14:0], 1'b0} ^ (fb ? prot_pkg::CRC_POLY : 16'h0000);
    end
    crc_o = c;
  end

endmodule : crc16_byte
`default_nettype wire

/* test/prot_write_path_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module prot_write_path_chk (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_ack_o, // Acknowledge
  input wire logic host_valid_i, // Host byte offered
  input wire logic host_ready_o, // Host byte taken
  input wire logic meta_valid_i, // Metadata offered
  input wire logic meta_ready_o, // Metadata taken
  input wire logic media_valid_o, // Media byte valid
  input wire logic [7:0] media_data_o, // Media byte
  input wire logic media_last_o, // Block end
  input wire logic media_ready_i // Media accepts
);
  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire take = (host_ready_o && host_valid_i) || (meta_ready_o && meta_valid_i);
  wire stall = media_valid_o && !media_ready_i;
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack");
  property p_no_ack; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  a_no_ack: assert property (p_no_ack) else $error("stray ack");
  property p_hold; stall |=> media_valid_o && $stable(media_data_o)
    && $stable(media_last_o); endproperty
  a_hold: assert property (p_hold) else $error("media byte lost");
  property p_full; stall |-> !host_ready_o && !meta_ready_o; endproperty
  a_full: assert property (p_full) else $error("ready while full");
  property p_drop; host_ready_o && host_valid_i |=> !host_ready_o; endproperty
  a_drop: assert property (p_drop) else $error("ready held");
  property p_take; take |=> media_valid_o; endproperty
  a_take: assert property (p_take) else $error("byte not forwarded");
  property p_rst; $fell(rst_i) |-> !wb_ack_o && !media_valid_o
    && !host_ready_o && !meta_ready_o; endproperty
  a_rst: assert property (p_rst) else $error("outputs after reset");
  c_last: cover property (media_valid_o && media_last_o && media_ready_i);
  c_meta: cover property (meta_ready_o && meta_valid_i);
  c_stall: cover property (stall);
endmodule : prot_write_path_chk
bind prot_write_path prot_write_path_chk prot_write_path_chk_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .host_valid_i(host_valid_i),
  .host_ready_o(host_ready_o), .meta_valid_i(meta_valid_i),
  .meta_ready_o(meta_ready_o), .media_valid_o(media_valid_o),
  .media_data_o(media_data_o), .media_last_o(media_last_o),
  .media_ready_i(media_ready_i));
`default_nettype wire

/* test/host_media_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_media_model (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic slow_i, // Media stalls every other cycle
  input wire logic host_ready_i, // Host byte taken
  output logic host_valid_o, // Host byte offered
  output logic [7:0] host_data_o, // Host byte
  input wire logic meta_ready_i, // Metadata taken
  output logic meta_valid_o, // Metadata offered
  output logic [7:0] meta_data_o, // Metadata byte
  input wire logic media_valid_i, // Media byte valid
  input wire logic [7:0] media_data_i, // Media byte
  input wire logic media_last_i, // Block end
  output logic media_ready_o // Media accepts
);
  // ----------------------------------------------------------------
  // Buffers and media capture
  // ----------------------------------------------------------------
  logic [7:0] hmem [256];
  logic [7:0] mmem [256];
  logic [7:0] cap [256];
  logic capl [256];
  logic [7:0] hlen = 8'h00, mlen = 8'h00;
  logic [7:0] hp, mp, cc, hlast, mlast;
  logic tog;
  // Idle lines show the inverse of the last byte, never a stale copy
  assign host_valid_o = hp != hlen;
  assign host_data_o = host_valid_o ? hmem[hp] : ~hlast;
  assign meta_valid_o = mp != mlen;
  assign meta_data_o = meta_valid_o ? mmem[mp] : ~mlast;
  assign media_ready_o = !slow_i || tog;
  always @(posedge clk_i) begin
    if (rst_i) begin
      hp <= 8'h00;
      mp <= 8'h00;
      cc <= 8'h00;
      hlast <= 8'h00;
      mlast <= 8'h00;
      tog <= 1'b0;
    end else begin
      tog <= ~tog;
      if (host_valid_o && host_ready_i) begin
        hlast <= host_data_o;
        hp <= hp + 8'h01;
      end
      if (meta_valid_o && meta_ready_i) begin
        mlast <= meta_data_o;
        mp <= mp + 8'h01;
      end
      if (media_valid_i && media_ready_o) begin
        cap[cc] <= media_data_i;
        capl[cc] <= media_last_i;
        cc <= cc + 8'h01;
      end
    end
  end
endmodule : host_media_model
`default_nettype wire

/* test/block_metadata_protection_write_path_test.sv */
`timescale 1ns/1ps
`default_nettype none
module block_metadata_protection_write_path_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, slow = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rd, rdat, st;
  logic ack, hv, hr, mv, mr, qv, ql, qr;
  logic [7:0] hd, md, qd;
  int fails = 0, compares = 0;
  logic [7:0] e[$];
  always #25 clk_i = ~clk_i;
  prot_write_path #(.BLK_BYTES(8)) prot_write_path_i (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rd),
    .wb_ack_o(ack), .host_valid_i(hv), .host_data_i(hd), .host_ready_o(hr),
    .meta_valid_i(mv), .meta_data_i(md), .meta_ready_o(mr),
    .media_valid_o(qv), .media_data_o(qd), .media_last_o(ql),
    .media_ready_i(qr));
  host_media_model m (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
    .host_ready_i(hr), .host_valid_o(hv), .host_data_o(hd),
    .meta_ready_i(mr), .meta_valid_o(mv), .meta_data_o(md),
    .media_valid_i(qv), .media_data_i(qd), .media_last_i(ql),
    .media_ready_o(qr));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 100);
    rdat = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    check({31'h0, ack}, 32'h1);
  endtask : wb
  task automatic push(input logic [7:0] q[$], input logic meta);
    foreach (q[i]) begin
      if (meta) m.mmem[m.mlen + i] = q[i];
      else m.hmem[m.hlen + i] = q[i];
    end
    if (meta) m.mlen <= m.mlen + 8'(q.size());
    else m.hlen <= m.hlen + 8'(q.size());
  endtask : push
  // Polls done, keeps status, clears sticky done
  task automatic run(input logic [31:0] f, c, a, r);
    int n;
    n = 0;
    wb(1'b1, 8'h00, f);
    wb(1'b1, 8'h08, a);
    wb(1'b1, 8'h0C, r);
    wb(1'b1, 8'h04, c);
    do begin
      wb(1'b0, 8'h10, 32'h0);
      n++;
    end while (rdat[1] !== 1'b1 && n < 400);
    check({31'h0, rdat[1]}, 32'h1);
    st = rdat;
    wb(1'b1, 8'h10, 32'h2);
  endtask : run
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'h0000;
    foreach (q[i]) for (int b = 7; b >= 0; b--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ q[i][b]) ? 16'h8BB7 : 16'h0000);
    return c;
  endfunction : crc
  task automatic media_is(input int c0);
    foreach (e[i]) check({24'h0, m.cap[c0 + i]}, {24'h0, e[i]});
  endtask : media_is
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_plain;
    int c0;
    c0 = m.cc;
    e.delete();
    for (int i = 0; i < 16; i++) e.push_back(8'(8'hA0 + i));
    push(e, 1'b0);
    slow <= 1'b1;
    run(32'h0000_0800, 32'h0001_0001, 32'h0, 32'h0);
    media_is(c0);
    check({31'h0, m.capl[c0 + 15]}, 32'h1);
    check({28'h0, st[3:0]}, 32'h2);
    wb(1'b0, 8'h40, 32'h0);
    check(rdat, 32'h0);
  endtask : s_plain
  task automatic s_gen;
    int c0, h0;
    logic [7:0] d[$], h[$];
    logic [15:0] g;
    c0 = m.cc;
    h0 = m.hp;
    e.delete();
    for (int b = 0; b < 2; b++) begin
      d.delete();
      for (int i = 0; i < 8; i++) d.push_back(8'(8'h30 + 8 * b + i));
      // One push only: two in one time step would reuse the old length
      h = {h, d};
      g = crc(d);
      e = {e, d, g[15:8], g[7:0], 8'h12, 8'h34, 8'h00, 8'h00, 8'h00,
        8'(8'h10 + b)};
    end
    push(h, 1'b0);
    slow <= 1'b0;
    run(32'h0000_0803, 32'h0002_0003, 32'h1234, 32'h10);
    media_is(c0);
    check(32'(m.hp) - 32'(h0), 32'h10);
    check({30'h0, st[3:2]}, 32'h0);
    wb(1'b0, 8'h14, 32'h0);
    check(rdat, 32'h12);
  endtask : s_gen
  task automatic s_chk;
    int c0;
    logic [7:0] d[$], q[$];
    logic [15:0] g;
    c0 = m.cc;
    for (int i = 0; i < 8; i++) d.push_back(8'(8'h50 + i));
    for (int i = 0; i < 8; i++) q.push_back(8'(8'h70 + i));
    g = crc({d, q});
    q = {q, g[15:8], g[7:0], 8'h5A, 8'h5A, 8'h00, 8'h00, 8'h00, 8'h99};
    push(d, 1'b0);
    push(q, 1'b1);
    e = {d, q};
    slow <= 1'b1;
    run(32'h0000_1015, 32'h0001_001D, 32'h5A5A, 32'h20);
    media_is(c0);
    check({30'h0, st[3:2]}, 32'h3);
  endtask : s_chk
  task automatic s_esc;
    int c0;
    c0 = m.cc;
    e.delete();
    for (int i = 0; i < 8; i++) e.push_back(8'(8'hC0 + i));
    e = {e, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h01};
    push(e, 1'b0);
    run(32'h0000_0803, 32'h0001_001D, 32'h1111, 32'h22);
    media_is(c0);
    check({30'h0, st[3:2]}, 32'h0);
  endtask : s_esc
  task automatic s_first;
    int c0, h0;
    logic [7:0] d[$], h[$];
    logic [15:0] g;
    c0 = m.cc;
    h0 = m.hp;
    e.delete();
    for (int b = 0; b < 2; b++) begin
      d.delete();
      for (int i = 0; i < 8; i++) d.push_back(8'(8'h60 + 8 * b + i));
      g = crc(d);
      e = {e, d, g[15:8], g[7:0], 8'hBE, 8'hEF,
        8'h00, 8'h00, 8'h00, 8'h07};
      for (int i = 0; i < 16; i++) d.push_back(8'(8'hE0 + i));
      h = {h, d};
      e = {e, d[16:23]};
    end
    push(h, 1'b0);
    slow <= 1'b1;
    run(32'h0000_100F, 32'h0002_0003, 32'hBEEF, 32'h7);
    media_is(c0);
    check(32'(m.hp) - 32'(h0), 32'h30);
    check({30'h0, st[3:2]}, 32'h0);
    wb(1'b0, 8'h14, 32'h0);
    check(rdat, 32'h7);
  endtask : s_first
  initial begin
    #1000000;
    fails++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    s_plain();
    s_gen();
    s_chk();
    s_esc();
    s_first();
    complete_run();
  end
endmodule : block_metadata_protection_write_path_test
`default_nettype wire
